/* File: hw/fqfc_regs.vh */
// Purpose: Constants for the fabric queue and flow control block.
// Assumes: 64-bit fabric words (8 bytes per beat), Avalon byte addressing.
// Notes:   Offsets are byte addresses of 32-bit words.
`ifndef FQFC_REGS_VH
`define FQFC_REGS_VH

// Register offsets
`define FQFC_OFS_CTRL      4'h0
`define FQFC_OFS_THRESH    4'h4
`define FQFC_OFS_STATUS    4'h8
`define FQFC_OFS_DROPS     4'hc

// Control fields
`define FQFC_CTRL_TO_EN    0
`define FQFC_CTRL_IRQ_EN   1
`define FQFC_CTRL_PORT_WRITE_DISABLE   2
`define FQFC_CTRL_RST      3'h0

// Status fields
`define FQFC_STAT_TO_ERR   0

// Threshold reset value in fabric clock cycles
`define FQFC_THRESH_RST    32'h0000ffff

// Work queue: 245 words of 8 bytes; a 276-byte packet takes 35 words
`define FQFC_WQ_DEPTH      8'hf5
`define FQFC_MAX_PKT_WORDS 8'h23

// Broadcast buffer: 280 bytes is 35 words, at most 8 packets
`define FQFC_BB_DEPTH      6'h23
`define FQFC_BB_MAX_PKTS   4'h8

`endif

/* File: hw/fqfc_bcast.v */
// Purpose: Broadcast buffer feeding one egress port.
// Assumes: Fed only by the multicast work queue, one 8-byte word per beat.
// Notes:   Store-and-forward; a packet is offered only once fully held.
`include "fqfc_regs.vh"

module fqfc_bcast (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        in_valid,
	input  wire [63:0] in_data,
	input  wire        in_eop,
	output wire        in_ready,
	output wire        out_valid,
	output wire [63:0] out_data,
	output wire        out_eop,
	input  wire        out_ready
);

	reg  [64:0] mem [0:34];
	reg  [5:0]  wr_ptr;
	reg  [5:0]  rd_ptr;
	reg  [5:0]  count;
	reg  [3:0]  held;
	reg  [3:0]  started;
	reg         in_pkt;
	wire        push;
	wire        pop;
	wire        push_end;
	wire        pop_end;

	// Pointer advance with wrap at the buffer depth
	function [5:0] bump;
		input [5:0] p;
		begin
			bump = (p == `FQFC_BB_DEPTH - 6'h1) ? 6'h0 : p + 6'h1;
		end
	endfunction

	// Room for 8 more bytes, and a new packet only below 8 held
	assign in_ready  = (count != `FQFC_BB_DEPTH) &&
		(in_pkt || started < `FQFC_BB_MAX_PKTS); // RQ17 RQ16
	assign push      = in_valid & in_ready; // RQ13
	assign push_end  = push & in_eop;
	// Offer data only when a whole packet is held
	assign out_valid = (held != 4'h0); // RQ15
	assign out_data  = mem[rd_ptr][63:0]; // RQ14
	assign out_eop   = mem[rd_ptr][64];
	assign pop       = out_valid & out_ready;
	assign pop_end   = pop & mem[rd_ptr][64];

	// Storage write
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= {in_eop, in_data};
	end

	// Pointers and occupancy
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr  <= 6'h0;
			rd_ptr  <= 6'h0;
			count   <= 6'h0;
			held    <= 4'h0;
			started <= 4'h0;
			in_pkt  <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= bump(wr_ptr);
			if (pop)
				rd_ptr <= bump(rd_ptr);
			count   <= count + {5'h0, push} - {5'h0, pop};
			held    <= held + {3'h0, push_end} - {3'h0, pop_end};
			started <= started + {3'h0, push & ~in_pkt} - {3'h0, pop_end};
			if (push)
				in_pkt <= ~in_eop;
		end
	end

endmodule

/* File: hw/fqfc_top.v */
// Purpose: Request-age timeout, multicast work queue and broadcast buffers.
// Assumes: One fabric clock REF_CLK; all inputs synchronous to it.
// Notes:   Four ingress ports, two egress ports, 64-bit words.
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`include "fqfc_regs.vh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: Start age timer when head packet of request queue issues its request.
// RQ2: At programmed threshold raise timeout interrupt, gated by enables.
// RQ3: On timeout drop head packet; transaction counts as not completed.
// RQ4: A timeout may raise a port-write request toward the host.
// RQ5: No timeout port-write when port-write disabled or timeout disabled.
// RQ6: Reordering a new packet to the head clears and restarts the timer.
// RQ7: Work queue accepts only from ingress ports, never broadcast buffers.
// RQ8: Work queue admits higher priority first, round robin within priority.
// RQ9: Work queue releases in arrival order, no watermarks.
// RQ10: Work queue forwards to broadcast buffers cut-through.
// RQ11: Work queue is circular, any start point, 245 words of 8 bytes.
// RQ12: Ingress told all priorities accepted only while 276 bytes fit.
// RQ13: Each broadcast buffer takes data only from the work queue.
// RQ14: Broadcast buffers deliver in arrival order, no watermarks.
// RQ15: Broadcast buffers are store-and-forward toward egress.
// RQ16: Broadcast buffer holds up to 8 packets within 280 bytes.
// RQ17: Broadcast buffer ready only while 8 bytes of space remain.
// RQ18: Packets go back to back; arbitration gap only after idle.
// RQ19: Cut-through stalls give egress idles; no other source meanwhile.
// RQ20: Interface moves one word per cycle each way concurrently.
// RQ21: Reorder only when head blocked and another packet can progress.
// RQ22: Age timer counts fabric cycles, compared with threshold each cycle.
// RQ23: Timeout flag stays until cleared; interrupt only while enabled.
module fqfc_top (
	input  wire         REF_CLK,
	input  wire         RST_N,
	input  wire [3:0]   AVS_ADDRESS,
	input  wire         AVS_READ,
	input  wire         AVS_WRITE,
	input  wire [31:0]  AVS_WRITEDATA,
	input  wire [3:0]   AVS_BYTEENABLE,
	output reg  [31:0]  AVS_READDATA,
	output wire         AVS_WAITREQUEST,
	input  wire         HEAD_REQ,
	input  wire         HEAD_GRANT,
	input  wire         HEAD_BLOCKED,
	input  wire         OTHER_CAN_GO,
	input  wire         REORDER_REQ,
	output wire         REORDER_OK,
	output reg          HEAD_DROP,
	output reg          PORT_WRITE_REQ,
	output wire         IRQ,
	input  wire [3:0]   ING_VALID,
	input  wire [255:0] ING_DATA,
	input  wire [3:0]   ING_EOP,
	input  wire [7:0]   ING_PRIO,
	output reg  [3:0]   ING_READY,
	output wire         WQ_ACCEPT,
	output wire [1:0]   EG_VALID,
	output wire [127:0] EG_DATA,
	output wire [1:0]   EG_EOP,
	input  wire [1:0]   EG_READY
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	reg  [2:0]  ctrl;
	reg  [31:0] thresh;
	reg         to_err;
	reg  [15:0] drops;
	reg         ack;
	reg  [31:0] rd_value;
	wire        acc;
	wire        wr_go;
	reg  [31:0] age;
	wire        age_clear;
	wire        hit;
	reg  [64:0] wq_mem [0:244];
	reg  [7:0]  wq_wr;
	reg  [7:0]  wq_rd;
	reg  [7:0]  wq_count;
	reg         locked;
	reg  [1:0]  lock_port;
	reg  [1:0]  last_port;
	reg         sel_valid;
	reg  [1:0]  sel_port;
	reg  [1:0]  cand;
	reg         found;
	integer     pr;
	integer     k;
	wire        wq_space;
	wire        push;
	wire        push_eop;
	wire [63:0] push_data;
	wire        wq_out_valid;
	wire [1:0]  bb_ready;
	wire        pop;

	// Next index of a pointer into the work queue ring
	function [7:0] wq_bump;
		input [7:0] p;
		begin
			wq_bump = (p == `FQFC_WQ_DEPTH - 8'h1) ? 8'h0 : p + 8'h1;
		end
	endfunction

	// Merge write data into a word under byte enables
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  be;
		integer      b;
		begin
			lane_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (be[b])
					lane_merge[b*8 +: 8] = wd[b*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then answer
	assign acc             = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = acc & ~ack;
	assign wr_go           = AVS_WRITE & ack;

	// Read mux; unmapped offsets read zero
	always @*
	begin
		rd_value = 32'h0;
		case (AVS_ADDRESS)
			`FQFC_OFS_CTRL:   rd_value = {29'h0, ctrl};
			`FQFC_OFS_THRESH: rd_value = thresh;
			`FQFC_OFS_STATUS: rd_value = {16'h0, wq_count, 7'h0, to_err};
			`FQFC_OFS_DROPS:  rd_value = {16'h0, drops};
			default:          rd_value = 32'h0;
		endcase
	end

	// Handshake and read data capture
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ack          <= 1'b0;
			AVS_READDATA <= 32'h0;
		end
		else
		begin
			ack <= acc & ~ack;
			if (AVS_READ & ~ack)
				AVS_READDATA <= rd_value;
		end
	end

	// Control and threshold registers
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl   <= `FQFC_CTRL_RST;
			thresh <= `FQFC_THRESH_RST;
		end
		else if (wr_go)
		begin
			if (AVS_ADDRESS == `FQFC_OFS_CTRL && AVS_BYTEENABLE[0])
				ctrl <= AVS_WRITEDATA[2:0];
			if (AVS_ADDRESS == `FQFC_OFS_THRESH)
				thresh <= lane_merge(thresh, AVS_WRITEDATA, AVS_BYTEENABLE);
		end
	end

	// Sticky timeout flag, write one to clear; a new hit wins the clear
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			to_err <= 1'b0;
		else if (hit)
			to_err <= 1'b1; // RQ23
		else if (wr_go && AVS_ADDRESS == `FQFC_OFS_STATUS && AVS_BYTEENABLE[0]
			&& AVS_WRITEDATA[`FQFC_STAT_TO_ERR])
			to_err <= 1'b0;
	end

	// Interrupt only while both enables are set
	assign IRQ = to_err & ctrl[`FQFC_CTRL_IRQ_EN] & ctrl[`FQFC_CTRL_TO_EN]; // RQ2 RQ23

	////////////////////////////////////////////////////////////////////////
	// Request-age timer

	// A reorder is permitted only with the head stuck and another ready
	assign REORDER_OK = REORDER_REQ & HEAD_BLOCKED & OTHER_CAN_GO; // RQ21
	// Timer restarts on reorder, grant, drop or when no request stands
	assign age_clear  = ~HEAD_REQ | HEAD_GRANT | REORDER_OK | HEAD_DROP; // RQ6
	// Threshold compared every cycle
	assign hit = HEAD_REQ & ~age_clear & (age >= thresh); // RQ22 RQ2

	// Count cycles while the head request waits
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			age <= 32'h0;
		else if (age_clear || hit)
			age <= 32'h0;
		else if (age != 32'hffffffff)
			age <= age + 32'h1; // RQ1 RQ22
	end

	// Drop pulse, port-write pulse and drop counter
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			HEAD_DROP      <= 1'b0;
			PORT_WRITE_REQ <= 1'b0;
			drops          <= 16'h0;
		end
		else
		begin
			HEAD_DROP      <= hit; // RQ3
			PORT_WRITE_REQ <= hit & ctrl[`FQFC_CTRL_TO_EN]
				& ~ctrl[`FQFC_CTRL_PORT_WRITE_DISABLE]; // RQ4 RQ5
			if (hit && drops != 16'hffff)
				drops <= drops + 16'h1; // RQ3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Multicast work queue ingress arbitration

	// New packets admitted only while a largest packet still fits
	assign WQ_ACCEPT = (`FQFC_WQ_DEPTH - wq_count) >= `FQFC_MAX_PKT_WORDS; // RQ12
	assign wq_space  = (wq_count != `FQFC_WQ_DEPTH);

	// Strict priority, round robin among equal priority
	always @*
	begin
		sel_valid = 1'b0;
		sel_port  = 2'h0;
		cand      = 2'h0;
		found     = 1'b0;
		if (locked)
		begin
			sel_valid = 1'b1; // RQ19
			sel_port  = lock_port;
		end
		else if (WQ_ACCEPT)
		begin
			for (pr = 3; pr >= 0; pr = pr - 1)
				for (k = 1; k <= 4; k = k + 1)
				begin
					cand = last_port + k[1:0];
					if (!found && ING_VALID[cand] && ING_PRIO[cand*2 +: 2] == pr[1:0])
					begin
						found    = 1'b1; // RQ8
						sel_port = cand;
					end
				end
			sel_valid = found;
		end
	end

	// Ready only to the selected ingress port
	always @*
	begin
		ING_READY = 4'h0;
		if (sel_valid && wq_space)
			ING_READY[sel_port] = 1'b1; // RQ7
	end

	assign push      = sel_valid & wq_space & ING_VALID[sel_port];
	assign push_eop  = ING_EOP[sel_port];
	assign push_data = ING_DATA[sel_port*64 +: 64];

	// Hold the port for the whole packet; release at the last word
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			locked    <= 1'b0;
			lock_port <= 2'h0;
			last_port <= 2'h0;
		end
		else if (push)
		begin
			locked    <= ~push_eop; // RQ18
			lock_port <= sel_port;
			if (!locked)
				last_port <= sel_port; // RQ8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Work queue ring storage

	// Store one word per cycle at the write pointer
	always @(posedge REF_CLK)
	begin
		if (push)
			wq_mem[wq_wr] <= {push_eop, push_data}; // RQ11
	end

	// Pointers and occupancy; strictly first in, first out
	always @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wq_wr    <= 8'h0;
			wq_rd    <= 8'h0;
			wq_count <= 8'h0;
		end
		else
		begin
			if (push)
				wq_wr <= wq_bump(wq_wr); // RQ11
			if (pop)
				wq_rd <= wq_bump(wq_rd); // RQ9
			wq_count <= wq_count + {7'h0, push} - {7'h0, pop};
		end
	end

	// Words leave as soon as stored, without waiting for the packet end
	assign wq_out_valid = (wq_count != 8'h0); // RQ10
	// Every broadcast buffer takes the word in the same cycle
	assign pop          = wq_out_valid & (&bb_ready); // RQ20

	////////////////////////////////////////////////////////////////////////
	// Broadcast buffers, one per egress port
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : bb
			fqfc_bcast fqfc_bcast_i (
				.clk       (REF_CLK),
				.rst_n     (RST_N),
				.in_valid  (pop), // RQ13
				.in_data   (wq_mem[wq_rd][63:0]),
				.in_eop    (wq_mem[wq_rd][64]),
				.in_ready  (bb_ready[g]),
				.out_valid (EG_VALID[g]),
				.out_data  (EG_DATA[g*64 +: 64]),
				.out_eop   (EG_EOP[g]),
				.out_ready (EG_READY[g])
			);
		end
	endgenerate

endmodule

/* File: test/fqfc_props.sv */
// Purpose: Port-level checks for fqfc_top.
// Assumes: One fabric clock, asynchronous active-low reset.
// Notes:   Attached by the bind after the module.
module fqfc_props (
	input wire         REF_CLK,
	input wire         RST_N,
	input wire         AVS_WRITE,
	input wire         HEAD_REQ,
	input wire         HEAD_BLOCKED,
	input wire         OTHER_CAN_GO,
	input wire         REORDER_REQ,
	input wire         REORDER_OK,
	input wire         HEAD_DROP,
	input wire         PORT_WRITE_REQ,
	input wire         IRQ,
	input wire [3:0]   ING_READY,
	input wire [1:0]   EG_VALID,
	input wire [127:0] EG_DATA,
	input wire [1:0]   EG_READY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////////////////
	// Timer, drop and interrupt
	property p_reorder;
		REORDER_OK == (REORDER_REQ && HEAD_BLOCKED && OTHER_CAN_GO);
	endproperty
	a_reorder: assert property (p_reorder) else $error("reorder grant wrong");
	property p_pw;
		PORT_WRITE_REQ |-> HEAD_DROP;
	endproperty
	a_pw: assert property (p_pw) else $error("port write without drop");
	property p_drop_pulse;
		HEAD_DROP |=> !HEAD_DROP;
	endproperty
	a_drop_pulse: assert property (p_drop_pulse) else $error("drop too long");
	property p_drop_req;
		HEAD_DROP |-> $past(HEAD_REQ);
	endproperty
	a_drop_req: assert property (p_drop_req) else $error("drop without request");
	property p_irq_rise;
		$rose(IRQ) |-> HEAD_DROP || $past(AVS_WRITE);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
	property p_irq_hold;
		IRQ && !AVS_WRITE |=> IRQ;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq lost");
	////////////////////////////////////////////////////////////////////////////
	// Ingress and egress
	property p_onehot;
		$onehot0(ING_READY);
	endproperty
	a_onehot: assert property (p_onehot) else $error("several ingress ready");
	property p_eg_hold;
		EG_VALID[0] && !EG_READY[0] |=> EG_VALID[0] && $stable(EG_DATA[63:0]);
	endproperty
	a_eg_hold: assert property (p_eg_hold) else $error("egress head changed");
endmodule

bind fqfc_top fqfc_props fqfc_props_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.AVS_WRITE(AVS_WRITE), .HEAD_REQ(HEAD_REQ), .HEAD_BLOCKED(HEAD_BLOCKED),
	.OTHER_CAN_GO(OTHER_CAN_GO), .REORDER_REQ(REORDER_REQ), .REORDER_OK(REORDER_OK),
	.HEAD_DROP(HEAD_DROP), .PORT_WRITE_REQ(PORT_WRITE_REQ), .IRQ(IRQ),
	.ING_READY(ING_READY), .EG_VALID(EG_VALID), .EG_DATA(EG_DATA), .EG_READY(EG_READY));

/* File: test/fqfc_egress_sink.sv */
// Purpose: Egress port model taking words from one broadcast buffer.
// Assumes: Ready is registered and moves just after a clock edge.
// Notes:   Hold stalls the port so that the buffers fill.
module fqfc_egress_sink (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        valid,
	input  wire        hold,
	output reg         ready,
	output reg  [15:0] words
);
	timeunit 1ns;
	timeprecision 1ps;
	// Take one word a cycle unless held, and count them
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ready <= 1'h0;
			words <= 16'h0;
		end
		else
		begin
			ready <= !hold;
			words <= words + {15'h0, valid && ready};
		end
	end
endmodule

/* File: test/fabric_queue_flow_control_bench.sv */
// Purpose: Self-checking bench for fqfc_top.
// Assumes: fqfc_regs.vh on the include path.
// Notes:   A packet engine feeds ingress; two sink models drain egress.
`include "fqfc_regs.vh"
module fabric_queue_flow_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic         REF_CLK = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
	logic         HEAD_REQ = 1'h0, HEAD_BLOCKED = 1'h0, OTHER_CAN_GO = 1'h0;
	logic         REORDER_REQ = 1'h0, pause = 1'h0, HEAD_GRANT = 1'h0;
	logic [3:0]   AVS_ADDRESS = 4'h0, ING_VALID, ING_EOP, acc;
	logic [31:0]  AVS_WRITEDATA = 32'h0, q;
	logic [7:0]   ING_PRIO = 8'h0, npkt [4] = '{4{8'h0}}, pc [4] = '{4{8'h0}};
	logic [15:0]  w [4] = '{4{16'h0}}, len = 16'h1;
	logic [255:0] ING_DATA;
	logic [1:0]   hold = 2'h0;
	logic [2:0]   cfg [3] = '{3'h3, 3'h7, 3'h2};
	logic [7:0]   order [$];
	logic [63:0]  eq [$];
	wire  [31:0]  AVS_READDATA;
	wire          AVS_WAITREQUEST, REORDER_OK, HEAD_DROP, PORT_WRITE_REQ, IRQ, WQ_ACCEPT;
	wire  [3:0]   ING_READY;
	wire  [1:0]   EG_VALID, EG_EOP, EG_READY;
	wire  [127:0] EG_DATA;
	wire  [15:0]  w0, w1;
	int           error_cnt = 0, n_compared = 0, n;
	always #4 REF_CLK = ~REF_CLK;
	fqfc_top fqfc_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.HEAD_REQ(HEAD_REQ), .HEAD_GRANT(HEAD_GRANT), .HEAD_BLOCKED(HEAD_BLOCKED),
		.OTHER_CAN_GO(OTHER_CAN_GO), .REORDER_REQ(REORDER_REQ), .REORDER_OK(REORDER_OK),
		.HEAD_DROP(HEAD_DROP), .PORT_WRITE_REQ(PORT_WRITE_REQ), .IRQ(IRQ),
		.ING_VALID(ING_VALID), .ING_DATA(ING_DATA), .ING_EOP(ING_EOP), .ING_PRIO(ING_PRIO),
		.ING_READY(ING_READY), .WQ_ACCEPT(WQ_ACCEPT), .EG_VALID(EG_VALID),
		.EG_DATA(EG_DATA), .EG_EOP(EG_EOP), .EG_READY(EG_READY));
	fqfc_egress_sink fqfc_egress_sink_i [1:0] (.clk(REF_CLK), .rst_n(RST_N),
		.valid(EG_VALID), .hold(hold), .ready(EG_READY), .words({w1, w0}));
	////////////////////////////////////////////////////////////////////////////
	// Packet engine: each word carries port, packet and word number
	always_comb
		for (int p = 0; p < 4; p++)
		begin
			ING_VALID[p] = npkt[p] != 8'h0 && !(pause && w[p] == 16'h2);
			ING_DATA[64*p+:64] = {32'h0, 8'(p), pc[p], w[p]};
			ING_EOP[p] = w[p] == len - 16'h1;
		end
	// Settled handshakes, and egress 0 words in arrival order
	always @(negedge REF_CLK)
	begin
		acc = ING_VALID & ING_READY;
		if (EG_VALID[0] && EG_READY[0])
			eq.push_back({EG_EOP[0], EG_DATA[62:0]});
	end
	// Step each port past the word taken at this edge
	always @(posedge REF_CLK)
		for (int p = 0; p < 4; p++)
			if (acc[p])
			begin
				w[p] <= ING_EOP[p] ? 16'h0 : w[p] + 16'h1;
				if (ING_EOP[p])
				begin
					npkt[p] <= npkt[p] - 8'h1;
					pc[p] <= pc[p] + 8'h1;
					order.push_back(8'(p));
				end
			end
	////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string s, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic end_of_test;
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic fail;
		error_cnt++;
		end_of_test();
	endtask
	// Bus cycle held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge REF_CLK);
			if (AVS_WAITREQUEST === 1'h0)
				break;
		end
		q = AVS_READDATA;
		AVS_READ <= 1'h0;
		AVS_WRITE <= 1'h0;
		if (i == 20)
			fail();
	endtask
	task automatic rd(input string s, input logic [3:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		check(s, q, e);
	endtask
	task automatic drops(input logic [31:0] e);
		int i;
		for (i = 0; i < 60; i++)
		begin
			@(negedge REF_CLK);
			if (HEAD_DROP === 1'h1)
				break;
			@(posedge REF_CLK);
		end
		check("drop delay", i, e);
		if (i == 60)
			fail();
	endtask
	task automatic await_pkts(input int k);
		for (n = 0; n < 2000 && order.size() < k; n++)
			@(negedge REF_CLK);
		if (n == 2000)
			fail();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (2) @(posedge REF_CLK);
		RST_N <= 1'h1;
		rd("ctrl", `FQFC_OFS_CTRL, 32'h0);
		rd("thresh", `FQFC_OFS_THRESH, `FQFC_THRESH_RST);
		bus(1'h1, `FQFC_OFS_THRESH, 32'h5);
		for (int k = 0; k < 3; k++)
		begin
			bus(1'h1, `FQFC_OFS_CTRL, {29'h0, cfg[k]});
			HEAD_REQ <= 1'h1;
			drops(32'h6);
			check("port write", PORT_WRITE_REQ, cfg[k][0] & !cfg[k][2]);
			@(posedge REF_CLK);
			HEAD_REQ <= 1'h0;
			@(negedge REF_CLK);
			check("irq", IRQ, cfg[k][0] & cfg[k][1]);
			rd("status", `FQFC_OFS_STATUS, 32'h1);
			bus(1'h1, `FQFC_OFS_STATUS, 32'h1);
			@(negedge REF_CLK);
			check("irq clear", IRQ, 1'h0);
		end
		rd("drops", `FQFC_OFS_DROPS, 32'h3);
		// Reorder restarts the age count
		@(posedge REF_CLK);
		HEAD_REQ <= 1'h1;
		HEAD_BLOCKED <= 1'h1;
		OTHER_CAN_GO <= 1'h1;
		repeat (3) @(posedge REF_CLK);
		REORDER_REQ <= 1'h1;
		@(negedge REF_CLK);
		check("reorder", REORDER_OK, 1'h1);
		@(posedge REF_CLK);
		REORDER_REQ <= 1'h0;
		drops(32'h6);
		@(posedge REF_CLK);
		OTHER_CAN_GO <= 1'h0;
		REORDER_REQ <= 1'h1;
		@(negedge REF_CLK);
		check("no reorder", REORDER_OK, 1'h0);
		@(posedge REF_CLK);
		REORDER_REQ <= 1'h0;
		HEAD_REQ <= 1'h0;
		// A grant restarts the age count as well
		repeat (3) @(posedge REF_CLK);
		HEAD_REQ <= 1'h1;
		repeat (3) @(posedge REF_CLK);
		HEAD_GRANT <= 1'h1;
		@(posedge REF_CLK);
		HEAD_GRANT <= 1'h0;
		drops(32'h6);
		@(posedge REF_CLK);
		HEAD_REQ <= 1'h0;
		// Priority first, round robin within a priority, back to back
		ING_PRIO <= 8'h3d;
		npkt <= '{4{8'h2}};
		await_pkts(8);
		check("gap", n <= 9, 1'h1);
		for (int i = 0; i < 8; i++)
			check("order", order[i], i < 4 ? (i % 2 ? 8'h3 - order[0] : order[0]) :
				(i < 6 ? 8'h0 : 8'h3));
		check("first", order[0] == 8'h1 || order[0] == 8'h2, 1'h1);
		// Egress waits for a whole packet
		@(posedge REF_CLK);
		len <= 16'h4;
		pause <= 1'h1;
		npkt[0] <= 8'h1;
		repeat (10) @(negedge REF_CLK);
		check("held", EG_VALID, 2'h0);
		@(posedge REF_CLK);
		pause <= 1'h0;
		await_pkts(9);
		for (n = 0; n < 8 && EG_VALID[0] !== 1'h1; n++)
			@(negedge REF_CLK);
		check("cut through", n < 3, 1'h1);
		repeat (8) @(negedge REF_CLK);
		for (int i = 0; i < 12; i++)
		begin
			check("egress", eq[i][31:24], i < 8 ? order[i] : 8'h0);
			check("egress eop", eq[i][63], i < 8 || i == 11);
		end
		// Broadcast buffer packet limit with egress stalled
		@(posedge REF_CLK);
		hold <= 2'h3;
		len <= 16'h1;
		npkt[0] <= 8'ha;
		await_pkts(19);
		repeat (20) @(negedge REF_CLK);
		rd("wq words", `FQFC_OFS_STATUS, 32'h201);
		hold <= 2'h0;
		for (n = 0; n < 2000 && w1 !== 16'h16; n++)
			@(negedge REF_CLK);
		check("drained", w1, 16'h16);
		if (n == 2000)
			fail();
		// Fill until refused, then drain
		@(posedge REF_CLK);
		hold <= 2'h3;
		len <= 16'h23;
		npkt[0] <= 8'h9;
		await_pkts(27);
		repeat (50) @(negedge REF_CLK);
		check("refused", order.size(), 32'h1b);
		check("accept", WQ_ACCEPT, 1'h0);
		rd("wq full", `FQFC_OFS_STATUS, {16'h0, `FQFC_WQ_DEPTH, 8'h1});
		hold <= 2'h0;
		for (n = 0; n < 3000 && w1 !== 16'h151; n++)
			@(negedge REF_CLK);
		check("all out", w1, 16'h151);
		if (n == 3000)
			fail();
		check("accept again", WQ_ACCEPT, 1'h1);
		end_of_test();
	end
endmodule
